// ### lips_pkg.sv
// Purpose: Shared constants and carrier types for the live insertion power sequencer
// Assumes: 100 MHz system clock
// Notes: Times are held in their own unit and converted to cycle counts here
package lips_pkg;

   // ***************************************************
   // Timing
   // ***************************************************
   localparam int CLK_FREQ_HZ = 100000000;
   localparam int OC_QUAL_NS = 35000;
   localparam int PG_DEGLITCH_NS = 10000;
   localparam int OC_QUAL_CYC = (OC_QUAL_NS * (CLK_FREQ_HZ / 1000000)) / 1000;
   localparam int PG_DEGLITCH_CYC = (PG_DEGLITCH_NS * (CLK_FREQ_HZ / 1000000)) / 1000;
   localparam int CNT_W = 12;
   localparam int SYNC_W = 17;

   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic RST_LOW = 1'h0;
   localparam logic RST_HIGH = 1'h1;

   // ***************************************************
   // Carriers
   // ***************************************************
   typedef struct packed {
      logic uv_12v;
      logic uv_m12v;
      logic uv_5v;
      logic uv_3v3;
   } lips_uvlo_t;

   typedef struct packed {
      logic good_12v;
      logic good_3v3;
      logic good_5v;
      logic good_m12v;
   } lips_outgood_t;

   typedef struct packed {
      logic off_cmd;
      logic led_set;
      logic reset_set;
   } lips_serial_t;

   typedef enum logic [1:0] {
      LIPS_OFF,
      LIPS_RAMP,
      LIPS_ON,
      LIPS_TRIPPED
   } lips_state_t;

endpackage

// ### lips_sync.sv
// Purpose: Two flop synchroniser bank for asynchronous flags
// Assumes: First stage is read only by the second stage
// Notes: Width set by package constant
`timescale 1ns/1ns
`default_nettype none
module lips_sync (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [lips_pkg::SYNC_W-1:0] async_in,
   output logic [lips_pkg::SYNC_W-1:0] sync_out
);
   import lips_pkg::*;

   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] meta_d;
   logic [SYNC_W-1:0] sync_q;
   logic [SYNC_W-1:0] sync_d;

   always_comb begin
      meta_d = clk_en ? async_in : meta_q;
      sync_d = clk_en ? meta_q : sync_q;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

endmodule
`default_nettype wire

// ### lips_timer.sv
// Purpose: Qualification counter that fires after a condition holds for a set number of cycles
// Assumes: Condition is synchronous
// Notes: Restarts whenever the condition goes away
`timescale 1ns/1ns
`default_nettype none
module lips_timer #(
   parameter int COUNT = 1
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic cond,
   output logic expired
);
   import lips_pkg::*;

   localparam logic [CNT_W-1:0] LAST = CNT_W'(COUNT - 1);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic exp_q;
   logic exp_d;

   always_comb begin
      cnt_d = cnt_q;
      exp_d = exp_q;
      if (clk_en) begin
         if (!cond) begin
            cnt_d = '0;
            exp_d = 1'b0;
         end else if (cnt_q == LAST) begin
            exp_d = 1'b1;
         end else begin
            cnt_d = cnt_q + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign expired = exp_q;

endmodule
`default_nettype wire

// ### lips_top.sv
// Purpose: Digital control of a plug-in card live insertion power controller
// Assumes: Analog loops are modelled as flags; serial latches arrive as plain ports
// Notes: All outputs are registered; active low pins use the _n suffix
`timescale 1ns/1ns
`default_nettype none

module lips_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic off_on,
   input wire logic reset_in_n,
   input wire logic card_present_detect_1,
   input wire logic card_present_detect_2,
   input wire lips_pkg::lips_uvlo_t undervoltage_lockout,
   input wire lips_pkg::lips_outgood_t out_good,
   input wire logic overcurrent,
   input wire logic timer_above_thresh,
   input wire lips_pkg::lips_serial_t serial_latch,
   output logic status_present_1,
   output logic status_present_2,
   output logic status_fault,
   output logic status_reset_in,
   output logic status_power_good,
   output logic fault_n,
   output logic power_good_n,
   output logic bus_isolate_enable,
   output logic reset_out_n,
   output logic led_n,
   output logic gate_charge,
   output logic gate_discharge,
   output logic switch_12v_on,
   output logic timer_release,
   output lips_pkg::lips_outgood_t out_discharge
);
   import lips_pkg::*;

   // ***************************************************
   // Input synchronisers
   // ***************************************************
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] syn;

   assign raw_in = {off_on, reset_in_n, card_present_detect_1, card_present_detect_2,
                    undervoltage_lockout, out_good, overcurrent, timer_above_thresh,
                    serial_latch};

   lips_sync u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .async_in(raw_in),
      .sync_out(syn)
   );

   logic s_off_on;
   logic s_reset_in_n;
   logic s_card_present_detect_1;
   logic s_card_present_detect_2;
   lips_uvlo_t s_uvlo;
   lips_outgood_t s_good;
   logic s_oc;
   logic s_timer_hi;
   lips_serial_t s_ser;

   assign {s_off_on, s_reset_in_n, s_card_present_detect_1, s_card_present_detect_2, s_uvlo, s_good, s_oc, s_timer_hi, s_ser} = syn;

   // ***************************************************
   // Qualification counters
   // ***************************************************
   logic oc_qualified;
   logic pg_lost;
   logic oc_cond;
   logic all_good;
   lips_state_t state_q;
   lips_state_t state_d;

   assign oc_cond = s_oc && s_timer_hi && (state_q == LIPS_ON);
   assign all_good = &s_good;

   lips_timer #(.COUNT(OC_QUAL_CYC)) u_oc_timer (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .cond(oc_cond),
      .expired(oc_qualified)
   );

   lips_timer #(.COUNT(PG_DEGLITCH_CYC)) u_pg_timer (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .cond(!all_good),
      .expired(pg_lost)
   );

   // ***************************************************
   // Sequencer
   // ***************************************************
   logic cmd_off;
   logic uv_any;
   logic off_prev_q;
   logic off_prev_d;
   logic clear_cycle;
   logic [1:0] warm_q;
   logic [1:0] warm_d;
   logic sync_ready;

   // Synchroniser shows reset zeros for two edges; sequencer waits for real samples
   assign sync_ready = warm_q[1];

   assign cmd_off = s_off_on || s_ser.off_cmd;
   assign uv_any = |s_uvlo;
   // Falling edge of combined off command ends a high then low cycle
   assign clear_cycle = off_prev_q && !cmd_off;

   always_comb begin
      state_d = state_q;
      off_prev_d = off_prev_q;
      warm_d = warm_q;
      if (clk_en) begin
         warm_d = {warm_q[0], 1'h1};
      end
      if (clk_en && sync_ready) begin
         off_prev_d = cmd_off;
         unique case (state_q)
            LIPS_OFF: begin
               if (!cmd_off && !uv_any) begin
                  state_d = LIPS_RAMP;
               end
            end
            LIPS_RAMP: begin
               if (cmd_off || uv_any) begin
                  state_d = LIPS_OFF;
               end else if (s_timer_hi) begin
                  state_d = LIPS_ON;
               end
            end
            LIPS_ON: begin
               if (oc_qualified) begin
                  state_d = LIPS_TRIPPED;
               end else if (cmd_off || uv_any) begin
                  state_d = LIPS_OFF;
               end
            end
            LIPS_TRIPPED: begin
               if (clear_cycle) begin
                  state_d = LIPS_OFF;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= LIPS_OFF;
         off_prev_q <= RST_LOW;
         warm_q <= '0;
      end else begin
         state_q <= state_d;
         off_prev_q <= off_prev_d;
         warm_q <= warm_d;
      end
   end

   // ***************************************************
   // Power good tracking
   // ***************************************************
   logic pg_q;
   logic pg_d;

   always_comb begin
      pg_d = pg_q;
      if (clk_en) begin
         if (all_good) begin
            pg_d = 1'b1;
         end else if (pg_lost) begin
            pg_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pg_q <= RST_LOW;
      end else begin
         pg_q <= pg_d;
      end
   end

   // ***************************************************
   // Registered outputs
   // ***************************************************
   typedef struct packed {
      logic pres1;
      logic pres2;
      logic fault;
      logic rst_in;
      logic pgood;
      logic fault_n;
      logic pg_n;
      logic isolate;
      logic rst_out_n;
      logic led_n;
      logic g_chg;
      logic g_dis;
      logic sw12;
      logic tmr_rel;
      lips_outgood_t dis;
   } lips_outs_t;

   lips_outs_t out_q;
   lips_outs_t out_d;
   logic sw_on;
   logic rst_low;

   assign sw_on = (state_q == LIPS_RAMP) || (state_q == LIPS_ON);
   assign rst_low = !s_reset_in_n || s_ser.reset_set || !pg_q;

   always_comb begin
      out_d = out_q;
      if (clk_en) begin
         out_d.pres1 = s_card_present_detect_1;
         out_d.pres2 = s_card_present_detect_2;
         out_d.fault = state_q == LIPS_TRIPPED;
         out_d.rst_in = s_reset_in_n;
         out_d.pgood = pg_q;
         out_d.fault_n = !(state_q == LIPS_TRIPPED);
         out_d.pg_n = !pg_q;
         out_d.isolate = !pg_q;
         out_d.rst_out_n = !rst_low;
         out_d.led_n = !(rst_low || s_ser.led_set);
         out_d.g_chg = sw_on;
         out_d.g_dis = !sw_on;
         out_d.sw12 = sw_on;
         out_d.tmr_rel = sw_on;
         out_d.dis = {4{!sw_on}};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= '{pres1: RST_LOW, pres2: RST_LOW, fault: RST_LOW, rst_in: RST_LOW, pgood: RST_LOW,
                    fault_n: RST_HIGH, pg_n: RST_HIGH, isolate: RST_HIGH, rst_out_n: RST_LOW,
                    led_n: RST_LOW, g_chg: RST_LOW, g_dis: RST_HIGH, sw12: RST_LOW,
                    tmr_rel: RST_LOW, dis: 4'hF};
      end else begin
         out_q <= out_d;
      end
   end

   assign status_present_1 = out_q.pres1;
   assign status_present_2 = out_q.pres2;
   assign status_fault = out_q.fault;
   assign status_reset_in = out_q.rst_in;
   assign status_power_good = out_q.pgood;
   assign fault_n = out_q.fault_n;
   assign power_good_n = out_q.pg_n;
   assign bus_isolate_enable = out_q.isolate;
   assign reset_out_n = out_q.rst_out_n;
   assign led_n = out_q.led_n;
   assign gate_charge = out_q.g_chg;
   assign gate_discharge = out_q.g_dis;
   assign switch_12v_on = out_q.sw12;
   assign timer_release = out_q.tmr_rel;
   assign out_discharge = out_q.dis;

   // ***************************************************
   // Assertions
   // ***************************************************
   uvlo_keeps_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && uv_any && state_q != LIPS_ON) |=> !(state_q inside {LIPS_RAMP, LIPS_ON}) || !clk_en)
      else $error("switches enabled during undervoltage");
   timer_held_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !sw_on) |=> !timer_release)
      else $error("timer released while off");
   no_trip_ramp_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_q == LIPS_RAMP) |=> state_q != LIPS_TRIPPED)
      else $error("trip before timer threshold");
   trip_drives_fault_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && state_q == LIPS_TRIPPED) |=> (!fault_n && gate_discharge && !switch_12v_on))
      else $error("trip did not raise fault and kill supplies");
   trip_holds_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_q == LIPS_TRIPPED && !clear_cycle) |=> state_q == LIPS_TRIPPED)
      else $error("trip cleared without on/off cycle");
   pg_follows_good_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && all_good) |=> pg_q)
      else $error("power good not asserted");
   pg_deglitch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (pg_q && $rose(!all_good)) |=> pg_q)
      else $error("power good dropped without deglitch");
   reset_in_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !s_reset_in_n) |=> !reset_out_n)
      else $error("reset out not low with reset in low");
   led_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && s_ser.led_set) |=> !led_n)
      else $error("led not lit with latch set");
   discharge_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !sw_on) |=> (out_discharge == 4'hF))
      else $error("discharge not enabled while off");

endmodule
`default_nettype wire

// ### lips_far_model.sv
// Purpose: Far side model of the supply switches, timer capacitor and output sense comparators
// Assumes: Counters and out_good change on the falling clock edge, as the bench drives; overcurrent follows switch_on at once
// Notes: Timer charge and supply ramp lengths are parameters
`timescale 1ns/1ns
`default_nettype none
module lips_far_model #(
   parameter int TIMER_CYC = 4200,
   parameter int RAMP_CYC = 20
) (
   input wire logic clk_sys,
   input wire logic switch_on,
   input wire logic timer_release,
   input wire logic oc_cmd,
   input wire logic [3:0] drop_mask,
   output logic overcurrent,
   output logic timer_above_thresh,
   output lips_pkg::lips_outgood_t out_good
);
   import lips_pkg::*;
   int tmr_q = 0;
   int ramp_q = 0;

   // ***************************************************
   // Timer capacitor and supply ramp
   // ***************************************************
   // Capacitor charges only while released; a held timer restarts from empty
   always @(negedge clk_sys) begin
      tmr_q <= timer_release ? tmr_q + 1 : 0;
      ramp_q <= switch_on ? ramp_q + 1 : 0;
   end

   // Every flag is a defined level at all times
   assign timer_above_thresh = (tmr_q >= TIMER_CYC);
   assign overcurrent = oc_cmd & switch_on;
   assign out_good = (ramp_q >= RAMP_CYC) ? lips_outgood_t'(~drop_mask) : lips_outgood_t'(4'h0);
endmodule
`default_nettype wire

// ### testbench.sv
// Purpose: Self-checking bench for the live insertion power sequencer
// Assumes: Inputs change on the falling edge; latency is sync plus two register stages
// Notes: Waits carry margins around the 3500 and 1000 cycle qualification counts
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import lips_pkg::*;
   logic clk_sys = 1'h0;
   logic rst_n = 1'h0;
   logic clk_en = 1'h1;
   logic off_on = 1'h1;
   logic reset_in_n = 1'h1;
   logic det1 = 1'h0;
   logic det2 = 1'h1;
   lips_uvlo_t uv = 4'h1;
   lips_serial_t ser = 3'h0;
   logic oc_cmd = 1'h0;
   logic [3:0] drop_mask = 4'h0;
   logic overcurrent, timer_above_thresh;
   lips_outgood_t out_good, out_discharge;
   logic status_present_1, status_present_2, status_fault, status_reset_in, status_power_good;
   logic fault_n, power_good_n, bus_isolate_enable, reset_out_n, led_n;
   logic gate_charge, gate_discharge, switch_12v_on, timer_release;
   int miscompares = 0;
   int check_count = 0;

   always #5 clk_sys = ~clk_sys;

   lips_top u_lips_top (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .off_on(off_on),
      .reset_in_n(reset_in_n), .card_present_detect_1(det1), .card_present_detect_2(det2),
      .undervoltage_lockout(uv), .out_good(out_good), .overcurrent(overcurrent),
      .timer_above_thresh(timer_above_thresh), .serial_latch(ser),
      .status_present_1(status_present_1), .status_present_2(status_present_2),
      .status_fault(status_fault), .status_reset_in(status_reset_in),
      .status_power_good(status_power_good), .fault_n(fault_n), .power_good_n(power_good_n),
      .bus_isolate_enable(bus_isolate_enable), .reset_out_n(reset_out_n), .led_n(led_n),
      .gate_charge(gate_charge), .gate_discharge(gate_discharge), .switch_12v_on(switch_12v_on),
      .timer_release(timer_release), .out_discharge(out_discharge));

   lips_far_model u_lips_far_model (.clk_sys(clk_sys), .switch_on(switch_12v_on),
      .timer_release(timer_release), .oc_cmd(oc_cmd), .drop_mask(drop_mask),
      .overcurrent(overcurrent), .timer_above_thresh(timer_above_thresh), .out_good(out_good));

   // ***************************************************
   // Tasks
   // ***************************************************
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic check(input logic [3:0] act, input logic [3:0] exp, input string msg);
      check_count++;
      if (act !== exp) begin
         miscompares++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   task automatic final_report();
      if (miscompares == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wait_pg();
      int n;
      n = 0;
      while (power_good_n !== 1'h0 && n < 6000) begin
         cyc(1);
         n++;
      end
      if (n == 6000) begin
         miscompares++;
         $display("ERROR %0t power good never came", $time);
         final_report();
      end
   endtask

   // ***************************************************
   // Sequence
   // ***************************************************
   initial begin
      cyc(20);
      rst_n = 1'h1;
      cyc(4);
      check({fault_n, power_good_n, bus_isolate_enable, reset_out_n}, 4'hE, "reset outputs");
      check({led_n, gate_discharge, gate_charge, switch_12v_on}, 4'h4, "reset drives");
      check(out_discharge, 4'hF, "reset discharge");
      check({status_present_1, status_present_2}, 4'h1, "present status");
      det1 = 1'h1;
      det2 = 1'h0;
      cyc(5);
      check({status_present_1, status_present_2}, 4'h2, "present status swap");
      off_on = 1'h0;
      for (int i = 0; i < 4; i++) begin
         uv = lips_uvlo_t'(4'h1 << i);
         cyc(10);
         check({gate_charge, switch_12v_on, timer_release}, 4'h0, "undervoltage hold");
         check(out_discharge, 4'hF, "undervoltage discharge");
      end
      uv = 4'h0;
      oc_cmd = 1'h1;
      cyc(10);
      check({gate_charge, switch_12v_on, timer_release, gate_discharge}, 4'hE, "power up");
      check(out_discharge, 4'h0, "discharge off");
      cyc(3800);
      check(fault_n, 1'h1, "trip before timer");
      oc_cmd = 1'h0;
      wait_pg();
      cyc(5);
      check({power_good_n, bus_isolate_enable, reset_out_n, led_n}, 4'h3, "power good");
      check({status_power_good, status_reset_in, status_fault}, 4'h6, "status copies");
      cyc(500);
      for (int i = 0; i < 4; i++) begin
         drop_mask = 4'h1 << i;
         cyc(990);
         check(power_good_n, 1'h0, "deglitch early");
         cyc(30);
         check({power_good_n, switch_12v_on, reset_out_n, led_n}, 4'hC, "power good lost");
         drop_mask = 4'h0;
         cyc(10);
         check(power_good_n, 1'h0, "power good back");
      end
      drop_mask = 4'h2;
      cyc(600);
      drop_mask = 4'h0;
      cyc(4);
      drop_mask = 4'h2;
      cyc(600);
      check(power_good_n, 1'h0, "deglitch restart");
      drop_mask = 4'h0;
      reset_in_n = 1'h0;
      cyc(5);
      check({reset_out_n, led_n}, 4'h0, "reset in");
      check(status_reset_in, 1'h0, "reset in status");
      reset_in_n = 1'h1;
      ser = 3'h1;
      cyc(5);
      check({reset_out_n, led_n}, 4'h0, "serial reset");
      ser = 3'h2;
      cyc(5);
      check({reset_out_n, led_n}, 4'h2, "serial led");
      ser = 3'h0;
      oc_cmd = 1'h1;
      cyc(3000);
      oc_cmd = 1'h0;
      cyc(5);
      oc_cmd = 1'h1;
      cyc(3400);
      check(fault_n, 1'h1, "overcurrent restart");
      cyc(200);
      check({fault_n, gate_discharge, gate_charge, switch_12v_on}, 4'h4, "trip");
      check(out_discharge, 4'hF, "trip discharge");
      check(status_fault, 1'h1, "fault status");
      oc_cmd = 1'h0;
      cyc(100);
      check({fault_n, switch_12v_on}, 4'h0, "trip held");
      off_on = 1'h1;
      cyc(10);
      off_on = 1'h0;
      oc_cmd = 1'h1;
      cyc(3800);
      check({fault_n, switch_12v_on, timer_release}, 4'h7, "fresh power up");
      oc_cmd = 1'h0;
      cyc(600);
      oc_cmd = 1'h1;
      cyc(3700);
      check(fault_n, 1'h0, "second trip");
      oc_cmd = 1'h0;
      ser = 3'h4;
      cyc(10);
      ser = 3'h0;
      cyc(10);
      check({fault_n, switch_12v_on}, 4'h3, "serial clear");
      clk_en = 1'h0;
      off_on = 1'h1;
      cyc(20);
      check(switch_12v_on, 1'h1, "frozen while disabled");
      clk_en = 1'h1;
      cyc(10);
      check({gate_charge, switch_12v_on, timer_release, gate_discharge}, 4'h1, "off command");
      check(out_discharge, 4'hF, "off discharge");
      final_report();
   end
endmodule
`default_nettype wire
